/* hw/mcu8_pkg.sv */
package mcu8_pkg;

  // Core widths
  localparam int PC_W = 10;
  localparam int STACK_DEPTH_DEF = 8;
  localparam logic [9:0] PC_ONE = 10'h001;
  localparam logic [9:0] RESET_VECTOR = 10'h000;

  // Reset values of the working registers and status flags
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic PD_N_RST = 1'b1;
  localparam logic TO_N_RST = 1'b1;

  // Instruction word fields (14-bit word)
  localparam int GRP_MSB = 13;
  localparam int GRP_LSB = 12;
  localparam int FN_MSB = 11;
  localparam int FN_LSB = 7;
  localparam int DEST_POS = 6;
  localparam int BIT_MSB = 9;
  localparam int BIT_LSB = 7;
  localparam int KIND_MSB = 11;
  localparam int KIND_LSB = 10;
  localparam int SUB_MSB = 6;
  localparam int SUB_LSB = 4;
  localparam int GOTO_ADR_MSB = 8;

  // Instruction groups
  localparam logic [1:0] GRP_REG = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_IMM = 2'h2;
  localparam logic [1:0] GRP_BR = 2'h3;

  // Register-operand functions
  localparam logic [4:0] FN_MISC = 5'h00;
  localparam logic [4:0] FN_ADD = 5'h01;
  localparam logic [4:0] FN_ADC = 5'h02;
  localparam logic [4:0] FN_SUB = 5'h03;
  localparam logic [4:0] FN_SBC = 5'h04;
  localparam logic [4:0] FN_AND = 5'h05;
  localparam logic [4:0] FN_OR = 5'h06;
  localparam logic [4:0] FN_XOR = 5'h07;
  localparam logic [4:0] FN_INC = 5'h08;
  localparam logic [4:0] FN_DEC = 5'h09;
  localparam logic [4:0] FN_INCSZ = 5'h0A;
  localparam logic [4:0] FN_DECSZ = 5'h0B;
  localparam logic [4:0] FN_CMP = 5'h0C;
  localparam logic [4:0] FN_MOVR = 5'h0D;
  localparam logic [4:0] FN_MOVAR = 5'h0E;
  localparam logic [4:0] FN_COM = 5'h0F;
  localparam logic [4:0] FN_CLRR = 5'h10;

  // Miscellaneous sub-operations, field [6:4] under FN_MISC
  localparam logic [2:0] MS_CTRL = 3'h0;
  localparam logic [2:0] MS_FWR = 3'h1;
  localparam logic [2:0] MS_FRD = 3'h2;
  localparam logic [2:0] MS_SWR = 3'h3;
  localparam logic [2:0] MS_SRD = 3'h4;

  // Control codes, field [3:0] under MS_CTRL
  localparam logic [3:0] CT_NOP = 4'h0;
  localparam logic [3:0] CT_SLEEP = 4'h1;
  localparam logic [3:0] CT_WATCHDOG_CLEAR_OP = 4'h2;
  localparam logic [3:0] CT_DAA = 4'h3;
  localparam logic [3:0] CT_RET = 4'h4;
  localparam logic [3:0] CT_CALL_BY_ACCUMULATOR = 4'h5;
  localparam logic [3:0] CT_JUMP_BY_ACCUMULATOR = 4'h6;
  localparam logic [3:0] CT_CLRA = 4'h7;

  // Immediate functions, field [11:8]
  localparam logic [3:0] IM_MOV = 4'h0;
  localparam logic [3:0] IM_ADD = 4'h1;
  localparam logic [3:0] IM_ADC = 4'h2;
  localparam logic [3:0] IM_SUB = 4'h3;
  localparam logic [3:0] IM_SBC = 4'h4;
  localparam logic [3:0] IM_AND = 4'h5;
  localparam logic [3:0] IM_OR = 4'h6;
  localparam logic [3:0] IM_XOR = 4'h7;

  // Bit-operation kinds and branch kinds, field [11:10]
  localparam logic [1:0] BK_SET = 2'h0;
  localparam logic [1:0] BK_CLR = 2'h1;
  localparam logic [1:0] BK_SKC = 2'h2;
  localparam logic [1:0] BK_SKS = 2'h3;
  localparam logic [1:0] BR_CALL = 2'h0;
  localparam logic [1:0] BR_GOTO = 2'h1;

  // Special-register page limits
  localparam logic [3:0] FPAGE_MIN = 4'h5;
  localparam logic PAGE_F = 1'b0;
  localparam logic PAGE_S = 1'b1;

  // Decimal adjust constants
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [8:0] BCD_LO_ADJ = 9'h006;
  localparam logic [8:0] BCD_HI_ADJ = 9'h060;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR,
    ALU_INC, ALU_DEC, ALU_COM, ALU_PASS, ALU_ZERO, ALU_DAA
  } alu_op_t;

  typedef enum logic [1:0] {PH_EXEC, PH_FLUSH, PH_HALT} phase_t;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } flags_t;

  typedef struct packed {
    logic [7:0] res;
    flags_t fl;
  } alu_out_t;

endpackage

/* hw/mcu8_alu.sv */
`timescale 1ns/1ps
module mcu8_alu (
  // Operation and operands
  input wire mcu8_pkg::alu_op_t op_i,
  input wire logic [7:0] opnd_i,
  input wire logic [7:0] acc_i,
  input wire mcu8_pkg::flags_t fl_i,
  // Result with a fresh zero flag; the carries pass through unless the operation updates them
  output mcu8_pkg::alu_out_t out_o
);
  import mcu8_pkg::*;

  logic [7:0] addend;
  logic cin;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [8:0] daa_lo;
  logic [8:0] daa_hi;
  logic lo_fix;
  logic hi_fix;

  // Subtraction is operand plus inverted accumulator; borrow forms feed the carry in
  always_comb begin
    addend = (op_i == ALU_SUB || op_i == ALU_SBC) ? ~acc_i : acc_i;
    case (op_i)
      ALU_SUB: cin = 1'b1;
      ALU_ADC, ALU_SBC: cin = fl_i.c;
      default: cin = 1'b0;
    endcase
    sum = {1'b0, opnd_i} + {1'b0, addend} + {8'h00, cin};
    nib = {1'b0, opnd_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
  end

  // Decimal adjust works on the accumulator after an add, using both carries
  always_comb begin
    lo_fix = (acc_i[3:0] > BCD_MAX) || fl_i.dc;
    daa_lo = {1'b0, acc_i} + (lo_fix ? BCD_LO_ADJ : 9'h000);
    hi_fix = (daa_lo[7:4] > BCD_MAX) || fl_i.c || daa_lo[8];
    daa_hi = {1'b0, daa_lo[7:0]} + (hi_fix ? BCD_HI_ADJ : 9'h000);
  end

  // Result select; carries only change for the add and subtract family, and the carry for decimal adjust
  always_comb begin
    out_o.fl = fl_i;
    case (op_i)
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
        out_o.res = sum[7:0];
        out_o.fl.c = sum[8];
        out_o.fl.dc = nib[4];
      end
      ALU_AND: out_o.res = acc_i & opnd_i;
      ALU_OR: out_o.res = acc_i | opnd_i;
      ALU_XOR: out_o.res = acc_i ^ opnd_i;
      ALU_INC: out_o.res = opnd_i + 8'h01;
      ALU_DEC: out_o.res = opnd_i - 8'h01;
      ALU_COM: out_o.res = ~opnd_i;
      ALU_ZERO: out_o.res = 8'h00;
      ALU_DAA: begin
        out_o.res = daa_hi[7:0];
        out_o.fl.c = hi_fix;
      end
      default: out_o.res = opnd_i;
    endcase
    out_o.fl.z = (out_o.res == 8'h00);
  end

endmodule

/* hw/mcu8_exec.sv */
`timescale 1ns/1ps
module mcu8_exec #(
  parameter int STACK_DEPTH = mcu8_pkg::STACK_DEPTH_DEF
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Program memory
  output logic [mcu8_pkg::PC_W-1:0] pc_o,
  input wire logic [13:0] instr_i,
  // General register page
  output logic [5:0] data_raddr_o,
  input wire logic [7:0] data_rdata_i,
  output logic data_we_o,
  output logic [5:0] data_waddr_o,
  output logic [7:0] data_wdata_o,
  // Special register pages
  output logic sfr_rpage_o,
  output logic [3:0] sfr_raddr_o,
  input wire logic [7:0] sfr_rdata_i,
  output logic sfr_we_o,
  output logic sfr_wpage_o,
  output logic [3:0] sfr_waddr_o,
  output logic [7:0] sfr_wdata_o,
  // High address bits for branches
  input wire logic [1:0] pc_high_buffer_i,
  input wire logic [1:0] table_high_pointer_i,
  // Watchdog and power control
  input wire logic wdt_timeout_i,
  input wire logic wake_i,
  output logic wdt_clear_o,
  output logic halt_o,
  // Core status
  output logic [7:0] accumulator_o,
  output mcu8_pkg::flags_t flags_o,
  output logic power_down_flag_n_o,
  output logic timeout_flag_n_o
);
  import mcu8_pkg::*;

  localparam int SP_W = $clog2(STACK_DEPTH);

  // The stack pointer wraps, so a non power of two depth would corrupt returns
  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_chk
    $error("STACK_DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    phase_t phase;
    logic [PC_W-1:0] pc;
    logic [7:0] acc;
    flags_t fl;
    logic pd_n;
    logic to_n;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
    logic [SP_W-1:0] sp;
    logic dwe;
    logic [5:0] dwaddr;
    logic [7:0] dwdata;
    logic swe;
    logic spage;
    logic [3:0] swaddr;
    logic [7:0] swdata;
    logic wdt_clr;
  } state_t;

  state_t st;
  state_t next_st;
  alu_op_t alu_op;
  alu_out_t alu;
  logic [1:0] grp;
  logic [4:0] fn;
  logic dbit;
  logic [5:0] raddr;
  logic [7:0] imm;
  logic [2:0] bitsel;
  logic [2:0] sub;
  logic [3:0] ctrl;
  logic [7:0] rd;
  logic [7:0] sfr_rd;
  logic sfr_sel;
  logic [PC_W-1:0] pc_inc;

  // Maps an instruction word onto the shared arithmetic unit
  function automatic alu_op_t alu_sel(input logic [13:0] w);
    alu_op_t r;
    r = ALU_PASS;
    if (w[GRP_MSB:GRP_LSB] == GRP_IMM) begin
      case (w[11:8])
        IM_ADD: r = ALU_ADD;
        IM_ADC: r = ALU_ADC;
        IM_SUB: r = ALU_SUB;
        IM_SBC: r = ALU_SBC;
        IM_AND: r = ALU_AND;
        IM_OR: r = ALU_OR;
        IM_XOR: r = ALU_XOR;
        default: r = ALU_PASS;
      endcase
    end else if (w[GRP_MSB:GRP_LSB] == GRP_REG) begin
      case (w[FN_MSB:FN_LSB])
        FN_MISC: r = (w[3:0] == CT_DAA) ? ALU_DAA : ALU_PASS;
        FN_ADD: r = ALU_ADD;
        FN_ADC: r = ALU_ADC;
        FN_SUB, FN_CMP: r = ALU_SUB;
        FN_SBC: r = ALU_SBC;
        FN_AND: r = ALU_AND;
        FN_OR: r = ALU_OR;
        FN_XOR: r = ALU_XOR;
        FN_INC, FN_INCSZ: r = ALU_INC;
        FN_DEC, FN_DECSZ: r = ALU_DEC;
        FN_COM: r = ALU_COM;
        FN_CLRR: r = ALU_ZERO;
        default: r = ALU_PASS;
      endcase
    end
    return r;
  endfunction

  // Field split of the word under execution
  assign grp = instr_i[GRP_MSB:GRP_LSB];
  assign fn = instr_i[FN_MSB:FN_LSB];
  assign dbit = instr_i[DEST_POS];
  assign raddr = instr_i[5:0];
  assign imm = instr_i[7:0];
  assign bitsel = instr_i[BIT_MSB:BIT_LSB];
  assign sub = instr_i[SUB_MSB:SUB_LSB];
  assign ctrl = instr_i[3:0];
  assign pc_inc = st.pc + PC_ONE;
  assign alu_op = alu_sel(instr_i);

  // Writes leave one cycle late, so a read of the same address is forwarded
  assign data_raddr_o = raddr;
  assign rd = (st.dwe && st.dwaddr == raddr) ? st.dwdata : data_rdata_i;
  assign sfr_sel = (sub == MS_SRD) ? PAGE_S : PAGE_F;
  assign sfr_rpage_o = sfr_sel;
  assign sfr_raddr_o = ctrl;
  assign sfr_rd = (st.swe && st.spage == sfr_sel && st.swaddr == ctrl) ? st.swdata
                                                                       : sfr_rdata_i;

  mcu8_alu u_alu (
    .op_i(alu_op),
    .opnd_i((grp == GRP_IMM) ? imm : rd),
    .acc_i(st.acc),
    .fl_i(st.fl),
    .out_o(alu)
  );

  // Execute, flush and halt sequencing
  always_comb begin
    next_st = st;
    next_st.dwe = 1'b0;
    next_st.swe = 1'b0;
    next_st.wdt_clr = 1'b0;
    next_st.dwaddr = raddr;
    case (st.phase)
      PH_HALT: begin
        if (wake_i) begin
          next_st.phase = PH_EXEC;
        end
      end
      PH_FLUSH: next_st.phase = PH_EXEC;
      PH_EXEC: begin
        next_st.pc = pc_inc;
        case (grp)
          GRP_REG: begin
            if (fn == FN_MISC) begin
              case (sub)
                MS_CTRL: begin
                  case (ctrl)
                    CT_SLEEP: begin
                      next_st.pd_n = 1'b0;
                      next_st.to_n = 1'b1;
                      next_st.wdt_clr = 1'b1;
                      next_st.phase = PH_HALT;
                    end
                    CT_WATCHDOG_CLEAR_OP: begin
                      next_st.pd_n = 1'b1;
                      next_st.to_n = 1'b1;
                      next_st.wdt_clr = 1'b1;
                    end
                    CT_DAA: begin
                      next_st.acc = alu.res;
                      next_st.fl.c = alu.fl.c;
                    end
                    CT_RET: begin
                      next_st.sp = st.sp - 1'b1;
                      next_st.pc = st.stk[st.sp - 1'b1];
                      next_st.phase = PH_FLUSH;
                    end
                    CT_CALL_BY_ACCUMULATOR, CT_JUMP_BY_ACCUMULATOR: begin
                      if (ctrl == CT_CALL_BY_ACCUMULATOR) begin
                        next_st.stk[st.sp] = pc_inc;
                        next_st.sp = st.sp + 1'b1;
                      end
                      next_st.pc = {table_high_pointer_i, st.acc};
                      next_st.phase = PH_FLUSH;
                    end
                    CT_CLRA: begin
                      next_st.acc = 8'h00;
                      next_st.fl.z = 1'b1;
                    end
                    default: ;
                  endcase
                end
                MS_FWR, MS_SWR: begin
                  // F-page cells below the first valid address are not written
                  next_st.swe = (sub == MS_SWR) || (ctrl >= FPAGE_MIN);
                  next_st.spage = (sub == MS_SWR) ? PAGE_S : PAGE_F;
                  next_st.swaddr = ctrl;
                  next_st.swdata = st.acc;
                end
                MS_FRD: next_st.acc = (ctrl >= FPAGE_MIN) ? sfr_rd : 8'h00;
                MS_SRD: next_st.acc = sfr_rd;
                default: ;
              endcase
            end else begin
              case (fn)
                FN_ADD, FN_ADC, FN_SUB, FN_SBC: next_st.fl = alu.fl;
                FN_CMP: begin
                  next_st.fl.z = alu.fl.z;
                  next_st.fl.c = alu.fl.c;
                end
                FN_INCSZ, FN_DECSZ: begin
                  if (alu.fl.z) begin
                    next_st.pc = st.pc + 10'h002;
                    next_st.phase = PH_FLUSH;
                  end
                end
                FN_MOVAR: ;
                default: next_st.fl.z = alu.fl.z;
              endcase
              if (fn == FN_MOVAR) begin
                next_st.dwe = 1'b1;
                next_st.dwdata = st.acc;
              end else if (fn != FN_CMP) begin
                if (dbit) begin
                  next_st.dwe = 1'b1;
                  next_st.dwdata = alu.res;
                end else begin
                  next_st.acc = alu.res;
                end
              end
            end
          end
          GRP_BIT: begin
            case (instr_i[KIND_MSB:KIND_LSB])
              BK_SET, BK_CLR: begin
                next_st.dwe = 1'b1;
                next_st.dwdata = rd;
                next_st.dwdata[bitsel] = (instr_i[KIND_MSB:KIND_LSB] == BK_SET);
              end
              default: begin
                if (rd[bitsel] == (instr_i[KIND_MSB:KIND_LSB] == BK_SKS)) begin
                  next_st.pc = st.pc + 10'h002;
                  next_st.phase = PH_FLUSH;
                end
              end
            endcase
          end
          GRP_IMM: begin
            next_st.acc = alu.res;
            case (instr_i[11:8])
              IM_ADD, IM_ADC, IM_SUB, IM_SBC: next_st.fl = alu.fl;
              IM_AND, IM_OR, IM_XOR: next_st.fl.z = alu.fl.z;
              default: ;
            endcase
          end
          default: begin
            if (instr_i[KIND_MSB:KIND_LSB] == BR_CALL) begin
              next_st.stk[st.sp] = pc_inc;
              next_st.sp = st.sp + 1'b1;
              next_st.pc = {pc_high_buffer_i, imm};
            end else begin
              next_st.pc = {pc_high_buffer_i[1], instr_i[GOTO_ADR_MSB:0]};
            end
            next_st.phase = PH_FLUSH;
          end
        endcase
      end
      default: next_st.phase = PH_EXEC;
    endcase
    // A timeout in the same cycle as a clearing instruction still lands
    if (wdt_timeout_i) begin
      next_st.to_n = 1'b0;
    end
  end

  // State register; power-up leaves both watchdog status flags high
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.phase <= PH_EXEC;
      st.pc <= RESET_VECTOR;
      st.acc <= ACC_RST;
      st.fl <= {FLAG_RST, FLAG_RST, FLAG_RST};
      st.pd_n <= PD_N_RST;
      st.to_n <= TO_N_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign pc_o = st.pc;
  assign data_we_o = st.dwe;
  assign data_waddr_o = st.dwaddr;
  assign data_wdata_o = st.dwdata;
  assign sfr_we_o = st.swe;
  assign sfr_wpage_o = st.spage;
  assign sfr_waddr_o = st.swaddr;
  assign sfr_wdata_o = st.swdata;
  assign wdt_clear_o = st.wdt_clr;
  assign halt_o = (st.phase == PH_HALT);
  assign accumulator_o = st.acc;
  assign flags_o = st.fl;
  assign power_down_flag_n_o = st.pd_n;
  assign timeout_flag_n_o = st.to_n;

  // Checks on execution results
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  logic ex;
  assign ex = (st.phase == PH_EXEC) && !wdt_timeout_i;

  AST_DEST_ACC: assert property (ex && grp == GRP_REG && fn == FN_ADD && !dbit
    |=> accumulator_o == $past(alu.res) && !data_we_o) else $error("dest 0 missed acc");
  AST_DEST_REG: assert property (ex && grp == GRP_REG && fn == FN_XOR && dbit
    |=> data_we_o && data_wdata_o == $past(st.acc ^ rd)) else $error("dest 1 missed reg");
  AST_ADD_CARRY: assert property (ex && grp == GRP_REG && fn == FN_ADD
    |=> flags_o.c == $past(({1'b0, st.acc} + {1'b0, rd}) > 9'h0FF))
    else $error("add carry wrong");
  AST_SUB_CARRY: assert property (ex && grp == GRP_IMM && instr_i[11:8] == IM_SUB
    |=> flags_o.c == $past(imm >= st.acc) && accumulator_o == $past(imm - st.acc))
    else $error("subtract wrong");
  AST_LOGIC_FLAGS: assert property (ex && grp == GRP_REG && fn == FN_AND
    |=> $stable(flags_o.c) && $stable(flags_o.dc)) else $error("logic op touched carry");
  AST_BIT_SET: assert property (ex && grp == GRP_BIT && instr_i[11:10] == BK_SET
    |=> data_we_o && data_wdata_o[$past(bitsel)] && $stable(flags_o))
    else $error("bit set failed");
  AST_SKIP: assert property (ex && grp == GRP_BIT && instr_i[11:10] == BK_SKS
    && rd[bitsel] |=> st.phase == PH_FLUSH ##1 st.phase == PH_EXEC
    && pc_o == $past(pc_o, 2) + 10'h002) else $error("skip timing wrong");
  AST_CALL: assert property (ex && grp == GRP_BR && instr_i[11:10] == BR_CALL
    |=> pc_o == {$past(pc_high_buffer_i), $past(imm)}
    && st.stk[$past(st.sp)] == $past(pc_inc) ##1 st.phase == PH_EXEC)
    else $error("call wrong");
  AST_SLEEP: assert property (ex && grp == GRP_REG && fn == FN_MISC && sub == MS_CTRL
    && ctrl == CT_SLEEP |=> halt_o && !power_down_flag_n_o && timeout_flag_n_o)
    else $error("sleep wrong");
  AST_TIMEOUT: assert property (wdt_timeout_i |=> !timeout_flag_n_o)
    else $error("timeout flag not cleared");
  AST_LOAD_IMM_OP: assert property (ex && grp == GRP_IMM && instr_i[11:8] == IM_MOV
    |=> accumulator_o == $past(imm) && $stable(flags_o)) else $error("move immediate wrong");

  COV_SKIP: cover property (ex && grp == GRP_BIT && st.phase == PH_EXEC ##1 st.phase == PH_FLUSH);
  COV_CALL_RET: cover property (ex && grp == GRP_BR ##[2:20] ex && grp == GRP_REG
    && fn == FN_MISC && sub == MS_CTRL && ctrl == CT_RET);
  COV_WAKE: cover property (halt_o ##[1:20] !halt_o);

endmodule

/* tb/mcu8_mem_model.sv */
`timescale 1ns/1ps
// Program memory plus general and special register pages as the core sees them
module mcu8_mem_model (
  // Clock
  input wire logic core_clk_i,
  // Program side
  input wire logic [9:0] pc_i,
  output logic [13:0] instr_o,
  // General page
  input wire logic [5:0] raddr_i,
  output logic [7:0] rdata_o,
  input wire logic we_i,
  input wire logic [5:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // Special pages, page bit on top of the index
  input wire logic rpage_i,
  input wire logic [3:0] sraddr_i,
  output logic [7:0] srdata_o,
  input wire logic swe_i,
  input wire logic wpage_i,
  input wire logic [3:0] swaddr_i,
  input wire logic [7:0] swdata_i
);
  logic [13:0] prog [1024];
  logic [7:0] regs [64];
  logic [7:0] sfr [32];
  // Same-cycle reads; no bypass, the core forwards its own late writes
  assign instr_o = prog[pc_i];
  assign rdata_o = regs[raddr_i];
  assign srdata_o = sfr[{rpage_i, sraddr_i}];
  // Writes land only on an edge that sees the strobe
  always @(posedge core_clk_i) begin
    if (we_i) begin
      regs[waddr_i] <= wdata_i;
    end
    if (swe_i) begin
      sfr[{wpage_i, swaddr_i}] <= swdata_i;
    end
  end
endmodule

/* tb/test_mcu8_exec.sv */
`timescale 1ns/1ps
module test_mcu8_exec;
  import mcu8_pkg::*;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] pc_hi = 2'h1;
  logic [1:0] tab_hi = 2'h2;
  logic wdt_to = 1'b0;
  logic wake = 1'b0;
  logic [9:0] pc;
  logic [13:0] instr;
  logic [5:0] raddr, waddr;
  logic [7:0] rdata, wdata, srdata, swdata, acc;
  logic we, rpage, swe, wpage, halt, pd_n, to_n, wclr;
  logic [9:0] clr_seen = 10'h000;
  logic [3:0] sraddr, swaddr;
  flags_t fl;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int pa;
  // Clock
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  mcu8_exec dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .pc_o(pc), .instr_i(instr),
    .data_raddr_o(raddr), .data_rdata_i(rdata), .data_we_o(we), .data_waddr_o(waddr),
    .data_wdata_o(wdata), .sfr_rpage_o(rpage), .sfr_raddr_o(sraddr), .sfr_rdata_i(srdata),
    .sfr_we_o(swe), .sfr_wpage_o(wpage), .sfr_waddr_o(swaddr), .sfr_wdata_o(swdata),
    .pc_high_buffer_i(pc_hi), .table_high_pointer_i(tab_hi), .wdt_timeout_i(wdt_to),
    .wake_i(wake), .wdt_clear_o(wclr), .halt_o(halt), .accumulator_o(acc), .flags_o(fl),
    .power_down_flag_n_o(pd_n), .timeout_flag_n_o(to_n));
  mcu8_mem_model mem (.core_clk_i(core_clk_i), .pc_i(pc), .instr_o(instr), .raddr_i(raddr),
    .rdata_o(rdata), .we_i(we), .waddr_i(waddr), .wdata_i(wdata), .rpage_i(rpage),
    .sraddr_i(sraddr), .srdata_o(srdata), .swe_i(swe), .wpage_i(wpage), .swaddr_i(swaddr),
    .swdata_i(swdata));
  // Instruction word builders
  function automatic logic [13:0] rop(logic [4:0] f, logic d, logic [5:0] r);
    return {GRP_REG, f, d, r};
  endfunction
  function automatic logic [13:0] imw(logic [3:0] f, logic [7:0] i);
    return {GRP_IMM, f, i};
  endfunction
  function automatic logic [13:0] bop(logic [1:0] k, logic [2:0] b, logic [5:0] r);
    return {GRP_BIT, k, b, 1'b0, r};
  endfunction
  function automatic logic [13:0] ctl(logic [2:0] s, logic [3:0] c);
    return {GRP_REG, FN_MISC, s, c};
  endfunction
  task automatic put(input logic [13:0] w);
    mem.prog[pa] = w;
    pa++;
  endtask
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Wait until the core parks itself; the cycle ceiling bounds this
  task automatic nap();
    do begin
      @(posedge core_clk_i);
      #1;
    end while (halt !== 1'b1);
  endtask
  task automatic run();
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk("pd_n", 10'h001, {9'h000, pd_n});
    chk("to_n", 10'h001, {9'h000, to_n});
    nap();
  endtask
  // A hang is cut short here; watchdog clear pulses are tallied on the way
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (wclr === 1'b1) begin
      clr_seen <= clr_seen + 10'h001;
    end
    if (cycles == 2000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem.prog[i] = 14'h0000;
      if (i < 64) mem.regs[i] = 8'h00;
      if (i < 32) mem.sfr[i] = 8'h00;
    end
    mem.regs[7] = 8'h5A;
    mem.regs[8] = 8'h01;
    mem.regs[9] = 8'h01;
    mem.regs[12] = 8'h07;
    mem.regs[15] = 8'h60;
    mem.regs[20] = 8'h0F;
    mem.regs[21] = 8'hF0;
    mem.sfr[7] = 8'hA5;
    mem.sfr[22] = 8'h3C;
    // Add to register, subtract immediate, then sleep
    pa = 0;
    put(imw(IM_MOV, 8'h12));
    put(rop(FN_MOVAR, 1'b1, 6'h05));
    put(imw(IM_MOV, 8'h34));
    put(rop(FN_ADD, 1'b1, 6'h05));
    put(imw(IM_SUB, 8'h50));
    put(ctl(MS_CTRL, CT_SLEEP));
    run();
    chk("r5", 10'h046, {2'h0, mem.regs[5]});
    chk("acc", 10'h01C, {2'h0, acc});
    chk("flags", 10'h001, {7'h00, fl});
    chk("pd_n", 10'h000, {9'h000, pd_n});
    // Carry out to zero, logic ops keep carry, back-to-back bit writes
    pa = 0;
    put(imw(IM_MOV, 8'hFF));
    put(imw(IM_ADD, 8'h01));
    put(imw(IM_MOV, 8'h5A));
    put(rop(FN_XOR, 1'b1, 6'h07));
    put(bop(BK_SET, 3'h7, 6'h08));
    put(bop(BK_CLR, 3'h0, 6'h08));
    put(ctl(MS_CTRL, CT_SLEEP));
    run();
    chk("r7", 10'h000, {2'h0, mem.regs[7]});
    chk("r8", 10'h080, {2'h0, mem.regs[8]});
    chk("acc", 10'h05A, {2'h0, acc});
    chk("flags", 10'h007, {7'h00, fl});
    // Skips, direct call and call through the accumulator
    pa = 0;
    put(rop(FN_DECSZ, 1'b1, 6'h09));
    put(rop(FN_INC, 1'b1, 6'h0C));
    put(bop(BK_SKS, 3'h0, 6'h09));
    put(rop(FN_INC, 1'b1, 6'h0D));
    put(bop(BK_SKC, 3'h3, 6'h09));
    put(rop(FN_INC, 1'b1, 6'h0C));
    put({GRP_BR, BR_CALL, 2'h0, 8'h20});
    put(ctl(MS_CTRL, CT_CALL_BY_ACCUMULATOR));
    put(ctl(MS_CTRL, CT_SLEEP));
    pa = 'h120;
    put(imw(IM_MOV, 8'h34));
    put(ctl(MS_CTRL, CT_RET));
    pa = 'h234;
    put(rop(FN_INC, 1'b1, 6'h0A));
    put(ctl(MS_CTRL, CT_RET));
    run();
    chk("r9", 10'h000, {2'h0, mem.regs[9]});
    chk("r12", 10'h007, {2'h0, mem.regs[12]});
    chk("r13", 10'h001, {2'h0, mem.regs[13]});
    chk("r10", 10'h001, {2'h0, mem.regs[10]});
    chk("pc", 10'h009, pc);
    // Add to acc, logic into reg, taken set-skip, borrow subtract, jumps, low F-page write
    pa = 0;
    put(imw(IM_MOV, 8'h81));
    put(rop(FN_ADD, 1'b0, 6'h14));
    put(rop(FN_AND, 1'b1, 6'h15));
    put(bop(BK_SKS, 3'h4, 6'h15));
    put(rop(FN_CLRR, 1'b1, 6'h14));
    put(rop(FN_SBC, 1'b1, 6'h14));
    put(rop(FN_COM, 1'b0, 6'h15));
    put(ctl(MS_CTRL, CT_JUMP_BY_ACCUMULATOR));
    pa = 'h26F;
    put(ctl(MS_FWR, 4'h2));
    put(ctl(MS_SWR, 4'h5));
    put(ctl(MS_SRD, 4'h6));
    put({GRP_BR, BR_GOTO, 1'b0, 9'h0A0});
    pa = 'h0A0;
    put(rop(FN_INCSZ, 1'b1, 6'h15));
    put(ctl(MS_CTRL, CT_SLEEP));
    run();
    chk("r20", 10'h07E, {2'h0, mem.regs[20]});
    chk("r21", 10'h091, {2'h0, mem.regs[21]});
    chk("acc", 10'h03C, {2'h0, acc});
    chk("flags", 10'h002, {7'h00, fl});
    chk("sfr21", 10'h06F, {2'h0, mem.sfr[21]});
    chk("sfr2", 10'h000, {2'h0, mem.sfr[2]});
    chk("pc", 10'h0A2, pc);
    // Decimal adjust, compare, page moves, watchdog flags
    pa = 0;
    put(imw(IM_MOV, 8'h28));
    put(imw(IM_ADD, 8'h25));
    put(ctl(MS_CTRL, CT_DAA));
    put(rop(FN_MOVAR, 1'b1, 6'h0E));
    put(rop(FN_CMP, 1'b0, 6'h0F));
    put(ctl(MS_SWR, 4'h3));
    put(ctl(MS_FRD, 4'h7));
    put(ctl(MS_CTRL, CT_SLEEP));
    put(ctl(MS_CTRL, CT_WATCHDOG_CLEAR_OP));
    put(ctl(MS_CTRL, CT_SLEEP));
    run();
    chk("r14", 10'h053, {2'h0, mem.regs[14]});
    chk("r15", 10'h060, {2'h0, mem.regs[15]});
    chk("flags", 10'h001, {7'h00, fl});
    chk("sfr", 10'h053, {2'h0, mem.sfr[19]});
    chk("acc", 10'h0A5, {2'h0, acc});
    @(posedge core_clk_i);
    wdt_to <= 1'b1;
    @(posedge core_clk_i);
    wdt_to <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk("to_n", 10'h000, {9'h000, to_n});
    @(posedge core_clk_i);
    wake <= 1'b1;
    @(posedge core_clk_i);
    wake <= 1'b0;
    nap();
    chk("to_n", 10'h001, {9'h000, to_n});
    // Let the last clear pulse be tallied; one per sleep or watchdog clear executed
    @(posedge core_clk_i);
    #1;
    chk("wdt_clear", 10'h007, clr_seen);
    close_out();
  end
endmodule
